// *** config_port_key_access_test.sv ***
// Self-checking bench for the configuration port key access block.
`timescale 1ns/1ps
module config_port_key_access_test;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic host_reset_drive = 1'h0;
    logic rts_n = 1'h1;
    logic pull = 1'h0;
    logic pin_in, pin_out, oe_n, config_mode, blocked, rv, io_rdata_valid, soft_pulse;
    int soft_pulses = 0;
    logic [7:0] io_rdata, rd;
    logic [15:0] ldev_active;
    cpka_pkg::cpka_io_req_t io_req;
    int miscompares = 0;
    int checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) rts_n <= 1'($urandom);
    always @(posedge sys_clk) if (soft_pulse === 1'h1) soft_pulses++;
    cpka_host_model host (.sys_clk(sys_clk), .strap_pull(pull), .strap_pin_out(pin_out),
        .strap_pin_oe_n(oe_n), .strap_pin_in(pin_in), .io_req(io_req), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid));
    cpka_config_port #(.POR_BLOCK(8), .NUM_LDEV(16)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .host_reset_drive(host_reset_drive), .io_req(io_req), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid), .strap_pin_in(pin_in), .strap_pin_out(pin_out),
        .strap_pin_oe_n(oe_n), .serial1_request_to_send_n(rts_n), .config_mode(config_mode),
        .ldev_active(ldev_active), .host_access_blocked(blocked), .soft_reset_pulse(soft_pulse));
    function automatic logic [15:0] base_of(input logic s);
        return s ? cpka_pkg::CFG_BASE_STRAP_HIGH : cpka_pkg::CFG_BASE_STRAP_LOW;
    endfunction : base_of
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host.io(1'h1, a, d, 1'h0, rd, rv);
    endtask : wr
    task automatic rdx(input logic [15:0] a, input logic [7:0] e);
        host.io(1'h0, a, 8'h00, 1'h0, rd, rv);
        chk({rv, rd}, {1'h1, e});
    endtask : rdx
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        #(25 * 2000);
        miscompares++;
        test_done();
    end
    initial begin
        logic [15:0] b;
        logic [3:0] ldn;
        void'($urandom(32'h104F));
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'h0;
        b = base_of(1'h0);
        wr(b, cpka_pkg::ENTRY_KEY);
        chk({blocked, config_mode}, 2'h2);
        for (int i = 0; i < 50 && blocked !== 1'h0; i++) @(posedge sys_clk);
        chk({blocked, config_mode, ldev_active}, 18'h0);
        repeat (20) begin
            host.io(1'($urandom), b + 16'($urandom_range(1)), 8'($urandom_range(8'h54)),
                1'h0, rd, rv);
            chk({config_mode, rv}, 2'h0);
        end
        host.io(1'h1, b, cpka_pkg::ENTRY_KEY, 1'h1, rd, rv);
        chk(config_mode, 1'h0);
        wr(b, cpka_pkg::ENTRY_KEY);
        chk(config_mode, 1'h1);
        wr(b, cpka_pkg::IDX_DEVICE_ID);
        rdx(b, cpka_pkg::IDX_DEVICE_ID);
        rdx(b + 16'h0001, cpka_pkg::DEVICE_ID_VALUE);
        rdx(b + 16'h0001, cpka_pkg::DEVICE_ID_VALUE);
        ldn = 4'($urandom);
        wr(b, cpka_pkg::IDX_LOGICAL_DEVICE);
        wr(b + 16'h0001, {4'h0, ldn});
        wr(b, cpka_pkg::IDX_ACTIVATE);
        wr(b + 16'h0001, 8'h01);
        chk(ldev_active, 16'h0001 << ldn);
        host.io(1'h0, b + 16'h0001, 8'h00, 1'h1, rd, rv);
        chk(rv, 1'h0);
        wr(b, cpka_pkg::IDX_BASE_LOW);
        rdx(b + 16'h0001, 8'hF0);
        wr(b, cpka_pkg::IDX_CONFIG_CONTROL);
        wr(b + 16'h0001, 8'h01);
        chk(ldev_active, 16'h0);
        chk(soft_pulses, 32'h1);
        wr(b, cpka_pkg::EXIT_KEY);
        chk(config_mode, 1'h0);
        @(posedge sys_clk);
        pull <= 1'h1;
        host_reset_drive <= 1'h1;
        repeat (2) @(posedge sys_clk);
        host_reset_drive <= 1'h0;
        #1 chk(oe_n, 1'h1);
        b = base_of(1'h1);
        wr(b, cpka_pkg::ENTRY_KEY);
        chk(config_mode, 1'h1);
        wr(b, cpka_pkg::IDX_BASE_LOW);
        rdx(b + 16'h0001, 8'h70);
        wr(b + 16'h0001, 8'h50);
        wr(16'h0350, cpka_pkg::EXIT_KEY);
        chk(config_mode, 1'h0);
        test_done();
    end
endmodule : config_port_key_access_test

// *** cpka_config_port.sv ***
// Configuration port decoder, key state machine and global configuration registers.
//
// Overview of operation
// - Hard or power-on reset gives Run state with all logical devices disabled.
// - Index and data ports decode only in Configuration state.
// - Base-select strap is sampled at host reset release or power-on reset.
// - Strap low decodes the ports at 0x03F0, strap high at 0x0370.
// - Software may relocate the port base through two global base registers.
// - Config port write-only; index port and data port at index plus one read/write.
// - Every decode is qualified by address enable being low.
// - Writing 0x55 to the config port enters Configuration state.
// - Writing 0xAA to the config port returns to Run state.
// - In Configuration state the index port shares the config port address.
// - Global registers are reachable whatever logical device is selected.
// - Exactly two states; Run accepts the entry key once the power-on block has ended.
// - The strap pin is shared with the first serial request-to-send output.
// - Setting bit 0 of the config control register triggers a soft reset.
// - All host accesses are blocked for 500 us after power-on reset.
`timescale 1ns/1ps
module cpka_config_port #(
    parameter int POR_BLOCK = cpka_pkg::POR_BLOCK_CYCLES,
    parameter int NUM_LDEV = cpka_pkg::NUM_LDEV
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic host_reset_drive,
    // Host I/O cycle
    input wire cpka_pkg::cpka_io_req_t io_req,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    // Shared strap and serial pin
    input wire logic strap_pin_in,
    output logic strap_pin_out,
    output logic strap_pin_oe_n,
    input wire logic serial1_request_to_send_n,
    // Configuration results
    output logic config_mode,
    output logic [NUM_LDEV-1:0] ldev_active,
    output logic host_access_blocked,
    output logic soft_reset_pulse
);

    cpka_pkg::cpka_state_t state;
    logic strap_high;
    logic [7:0] index_reg;
    logic [cpka_pkg::LDN_W-1:0] ldn;
    logic [7:0] config_base_low_reg;
    logic [7:0] config_base_high_reg;
    logic base_from_strap;
    logic [15:0] cfg_base;
    logic [$clog2(POR_BLOCK+1)-1:0] por_count;
    logic hit_index;
    logic hit_data;
    logic wr_index;
    logic wr_data;
    logic rd_data;
    logic any_reset;

    cpka_strap_latch u_strap (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .host_reset_drive(host_reset_drive),
        .strap_pin_in(strap_pin_in),
        .strap_pin_out(strap_pin_out),
        .strap_pin_oe_n(strap_pin_oe_n),
        .serial1_request_to_send_n(serial1_request_to_send_n),
        .strap_high(strap_high)
    );

    function automatic logic addr_hit(input cpka_pkg::cpka_io_req_t r, input logic [15:0] a);
        addr_hit = (r.addr == a) && !r.aen;
    endfunction : addr_hit

    assign any_reset = host_reset_drive;
    assign host_access_blocked = (por_count != '0);
    assign config_mode = (state == cpka_pkg::CPKA_CONFIG);

    // Strap picks the base until software writes either base register.
    assign cfg_base = base_from_strap
        ? (strap_high ? cpka_pkg::CFG_BASE_STRAP_HIGH : cpka_pkg::CFG_BASE_STRAP_LOW)
        : {config_base_high_reg, config_base_low_reg};

    assign hit_index = addr_hit(io_req, cfg_base) && !host_access_blocked;
    assign hit_data = addr_hit(io_req, cfg_base + cpka_pkg::DATA_PORT_OFFSET)
        && !host_access_blocked;
    assign wr_index = hit_index && io_req.iow && config_mode;
    assign wr_data = hit_data && io_req.iow && config_mode;
    assign rd_data = hit_data && io_req.ior && config_mode;

    // Power-on blocking window; a host reset alone does not restart it.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            por_count <= ($clog2(POR_BLOCK+1))'(POR_BLOCK);
        end else if (por_count != '0) begin
            por_count <= por_count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= cpka_pkg::CPKA_RUN;
        end else if (any_reset) begin
            state <= cpka_pkg::CPKA_RUN;
        end else if (hit_index && io_req.iow) begin
            case (state)
                cpka_pkg::CPKA_RUN: begin
                    if (io_req.wdata == cpka_pkg::ENTRY_KEY) begin
                        state <= cpka_pkg::CPKA_CONFIG;
                    end
                end
                cpka_pkg::CPKA_CONFIG: begin
                    if (io_req.wdata == cpka_pkg::EXIT_KEY) begin
                        state <= cpka_pkg::CPKA_RUN;
                    end
                end
                default: begin
                    state <= cpka_pkg::CPKA_RUN;
                end
            endcase
        end
    end

    // A write in Run state that is not the entry key changes nothing.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            index_reg <= cpka_pkg::RESET_INDEX;
        end else if (any_reset) begin
            index_reg <= cpka_pkg::RESET_INDEX;
        end else if (wr_index && io_req.wdata != cpka_pkg::EXIT_KEY) begin
            index_reg <= io_req.wdata;
        end
    end

    // Soft reset clears the device selection and activation but keeps the base.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ldn <= '0;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= 1'b0;
            if (any_reset) begin
                ldn <= '0;
            end else if (wr_data && index_reg == cpka_pkg::IDX_CONFIG_CONTROL
                    && io_req.wdata[cpka_pkg::SOFT_RESET_BIT]) begin
                soft_reset_pulse <= 1'b1;
                ldn <= '0;
            end else if (wr_data && index_reg == cpka_pkg::IDX_LOGICAL_DEVICE) begin
                ldn <= io_req.wdata[cpka_pkg::LDN_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            base_from_strap <= 1'b1;
            config_base_low_reg <= cpka_pkg::RESET_DATA;
            config_base_high_reg <= cpka_pkg::RESET_DATA;
        end else if (any_reset) begin
            base_from_strap <= 1'b1;
        end else if (wr_data && index_reg == cpka_pkg::IDX_BASE_LOW) begin
            if (base_from_strap) begin
                config_base_high_reg <= cfg_base[15:8];
            end
            config_base_low_reg <= io_req.wdata;
            base_from_strap <= 1'b0;
        end else if (wr_data && index_reg == cpka_pkg::IDX_BASE_HIGH) begin
            if (base_from_strap) begin
                config_base_low_reg <= cfg_base[7:0];
            end
            config_base_high_reg <= io_req.wdata;
            base_from_strap <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LDEV; g++) begin : g_ldev
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ldev_active[g] <= 1'b0;
                end else if (any_reset || soft_reset_pulse) begin
                    ldev_active[g] <= 1'b0;
                end else if (wr_data && index_reg == cpka_pkg::IDX_ACTIVATE
                        && ldn == (cpka_pkg::LDN_W)'(g)) begin
                    ldev_active[g] <= io_req.wdata[cpka_pkg::ACTIVATE_BIT];
                end
            end
        end
    endgenerate

    // Config port is write-only in Run state; in Configuration state the index and data ports both return a byte.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            io_rdata <= cpka_pkg::READ_IDLE;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata_valid <= rd_data || (hit_index && io_req.ior && config_mode);
            if (hit_index && io_req.ior && config_mode) begin
                io_rdata <= index_reg;
            end else if (rd_data) begin
                case (index_reg)
                    cpka_pkg::IDX_LOGICAL_DEVICE: io_rdata <= 8'(ldn);
                    cpka_pkg::IDX_DEVICE_ID: io_rdata <= cpka_pkg::DEVICE_ID_VALUE;
                    cpka_pkg::IDX_DEVICE_REV: io_rdata <= cpka_pkg::DEVICE_REV_VALUE;
                    cpka_pkg::IDX_BASE_LOW: io_rdata <= cfg_base[7:0];
                    cpka_pkg::IDX_BASE_HIGH: io_rdata <= cfg_base[15:8];
                    cpka_pkg::IDX_ACTIVATE: io_rdata <= {7'h00, ldev_active[ldn]};
                    default: io_rdata <= cpka_pkg::RESET_DATA;
                endcase
            end
        end
    end

endmodule : cpka_config_port

// *** cpka_config_port_props.sv ***
// Checker for the configuration port key access block.
`timescale 1ns/1ps
module cpka_config_port_props #(
    parameter int POR_BLOCK = 8,
    parameter int NUM_LDEV = 16
) (
    // Clock, resets and host cycle
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic host_reset_drive,
    input wire cpka_pkg::cpka_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_valid,
    // Pin and results
    input wire logic strap_pin_in,
    input wire logic strap_pin_out,
    input wire logic strap_pin_oe_n,
    input wire logic serial1_request_to_send_n,
    input wire logic config_mode,
    input wire logic [NUM_LDEV-1:0] ldev_active,
    input wire logic host_access_blocked,
    input wire logic soft_reset_pulse
);
    logic pend;
    logic strap;
    int cnt;
    logic [15:0] base;
    logic moved;
    logic [7:0] idx;
    assign base = strap ? cpka_pkg::CFG_BASE_STRAP_HIGH : cpka_pkg::CFG_BASE_STRAP_LOW;
    // Mirrors the strap capture; checks skip the edge where the capture is still pending.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend <= 1'h1;
            strap <= 1'h0;
        end else if (host_reset_drive) begin
            pend <= 1'h1;
        end else if (pend) begin
            pend <= 1'h0;
            strap <= strap_pin_in;
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) cnt <= 0;
        else if (cnt <= POR_BLOCK) cnt <= cnt + 1;
    end
    // Once software relocates the base, the strap-derived address no longer applies.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            moved <= 1'h0;
            idx <= 8'h00;
        end else if (host_reset_drive) begin
            moved <= 1'h0;
            idx <= 8'h00;
        end else if (config_mode && io_req.iow && !io_req.aen && !pend && !moved) begin
            if (io_req.addr == base && io_req.wdata != cpka_pkg::EXIT_KEY) begin
                idx <= io_req.wdata;
            end
            if (io_req.addr == base + 16'h0001
                    && (idx == cpka_pkg::IDX_BASE_LOW || idx == cpka_pkg::IDX_BASE_HIGH)) begin
                moved <= 1'h1;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence hit(logic w, logic [15:0] a);
        !io_req.aen && !host_access_blocked && !pend && !moved && !host_reset_drive
            && io_req.addr == a
            && (w ? io_req.iow : io_req.ior);
    endsequence
    run_after_reset_a: assert property ($fell(sys_rst) |-> !config_mode && ldev_active == '0)
        else $error("not in run state after reset");
    block_window_a: assert property (cnt < POR_BLOCK - 1 |-> host_access_blocked)
        else $error("access window opened early");
    block_end_a: assert property (cnt > POR_BLOCK |-> !host_access_blocked)
        else $error("access window never opened");
    block_ignore_a: assert property (host_access_blocked |=> $stable(config_mode))
        else $error("blocked access changed state");
    entry_key_a: assert property (!config_mode && io_req.wdata == cpka_pkg::ENTRY_KEY
        ##0 hit(1'h1, base) |=> config_mode) else $error("entry key not taken");
    exit_key_a: assert property (config_mode && io_req.wdata == cpka_pkg::EXIT_KEY
        ##0 hit(1'h1, base) |=> !config_mode) else $error("exit key not taken");
    run_nokey_a: assert property (!config_mode && io_req.wdata != cpka_pkg::ENTRY_KEY
        |=> !config_mode) else $error("left run state without key");
    dma_ignore_a: assert property (io_req.aen && !host_reset_drive
        |=> $stable(config_mode) && !io_rdata_valid) else $error("cycle with address enable decoded");
    hard_reset_a: assert property (host_reset_drive |=> !config_mode && ldev_active == '0)
        else $error("not in run state after host reset");
    soft_clear_a: assert property (soft_reset_pulse |=> ldev_active == '0)
        else $error("soft reset left a device active");
    run_read_a: assert property (!config_mode && io_req.ior |=> !io_rdata_valid)
        else $error("read answered in run state");
    index_read_a: assert property (config_mode ##0 hit(1'h0, base) |=> io_rdata_valid)
        else $error("index port read not answered");
    oe_reset_a: assert property (host_reset_drive |=> strap_pin_oe_n)
        else $error("pin driven during host reset");
    pin_share_a: assert property (!strap_pin_oe_n
        |-> strap_pin_out == $past(serial1_request_to_send_n)) else $error("pin not shared");
endmodule : cpka_config_port_props
bind cpka_config_port cpka_config_port_props #(.POR_BLOCK(POR_BLOCK), .NUM_LDEV(NUM_LDEV)) props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .host_reset_drive(host_reset_drive),
    .io_req(io_req), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .strap_pin_in(strap_pin_in), .strap_pin_out(strap_pin_out),
    .strap_pin_oe_n(strap_pin_oe_n), .serial1_request_to_send_n(serial1_request_to_send_n),
    .config_mode(config_mode), .ldev_active(ldev_active),
    .host_access_blocked(host_access_blocked), .soft_reset_pulse(soft_reset_pulse));

// *** cpka_host_model.sv ***
// Host model issuing single I/O cycles and resolving the shared strap pin.
`timescale 1ns/1ps
module cpka_host_model (
    // Clock
    input wire logic sys_clk,
    // Shared pin
    input wire logic strap_pull,
    input wire logic strap_pin_out,
    input wire logic strap_pin_oe_n,
    output logic strap_pin_in,
    // Host I/O cycle
    output cpka_pkg::cpka_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_valid
);
    // The strap resistor sets the level whenever the pin is not driven.
    assign strap_pin_in = strap_pin_oe_n ? strap_pull : strap_pin_out;
    initial io_req = '0;
    // Idle cycles show inverted address and data so stale values cannot pass.
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
                      input logic dma, output logic [7:0] rd, output logic rv);
        @(posedge sys_clk);
        io_req <= '{addr: a, wdata: d, aen: dma, ior: !w, iow: w};
        @(posedge sys_clk);
        io_req <= '{addr: ~a, wdata: ~d, aen: 1'h0, ior: 1'h0, iow: 1'h0};
        // The answer stands for one cycle only, so it is taken just after the edge that launches it.
        #1;
        rd = io_rdata;
        rv = io_rdata_valid;
        @(posedge sys_clk);
        #1;
    endtask : io
endmodule : cpka_host_model

// *** cpka_pkg.sv ***
// Package with constants and carrier types for the configuration port key access block.
package cpka_pkg;

    localparam logic [15:0] CFG_BASE_STRAP_LOW = 16'h03F0;
    localparam logic [15:0] CFG_BASE_STRAP_HIGH = 16'h0370;
    localparam logic [7:0] ENTRY_KEY = 8'h55;
    localparam logic [7:0] EXIT_KEY = 8'hAA;

    localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
    localparam logic [7:0] IDX_LOGICAL_DEVICE = 8'h07;
    localparam logic [7:0] IDX_DEVICE_ID = 8'h20;
    localparam logic [7:0] IDX_DEVICE_REV = 8'h21;
    localparam logic [7:0] IDX_BASE_LOW = 8'h26;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h27;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;

    localparam int SOFT_RESET_BIT = 0;
    localparam int ACTIVATE_BIT = 0;
    localparam logic [7:0] RESET_INDEX = 8'h00;
    localparam logic [7:0] RESET_LDN = 8'h00;
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'hFF;
    localparam logic [15:0] DATA_PORT_OFFSET = 16'h0001;

    localparam int NUM_LDEV = 16;
    localparam int LDN_W = 4;

    localparam int CLK_HZ = 40_000_000;
    localparam int POR_BLOCK_US = 500;
    localparam int POR_BLOCK_CYCLES = (POR_BLOCK_US * (CLK_HZ / 1_000_000));

    // Arbitrary identification values, not tied to any real part.
    localparam logic [7:0] DEVICE_ID_VALUE = 8'h5A;
    localparam logic [7:0] DEVICE_REV_VALUE = 8'h01;

    typedef enum logic [1:0] {
        CPKA_RUN = 2'b01,
        CPKA_CONFIG = 2'b10
    } cpka_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic aen;
        logic ior;
        logic iow;
    } cpka_io_req_t;

endpackage : cpka_pkg

// *** cpka_strap_latch.sv ***
// Strap capture and pin sharing between the base-select strap and the serial request-to-send.
`timescale 1ns/1ps
module cpka_strap_latch (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Host reset drive level
    input wire logic host_reset_drive,
    // Shared pin
    input wire logic strap_pin_in,
    output logic strap_pin_out,
    output logic strap_pin_oe_n,
    // Serial port side
    input wire logic serial1_request_to_send_n,
    // Captured strap
    output logic strap_high
);

    logic reset_seen;
    logic rst_dly;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_dly <= 1'b1;
        end else begin
            rst_dly <= host_reset_drive;
        end
    end

    // Capture on release of either reset; the pin level is clocked in, never loaded by reset.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_seen <= 1'b1;
            strap_high <= 1'b0;
        end else if (reset_seen || (rst_dly && !host_reset_drive)) begin
            if (!host_reset_drive) begin
                strap_high <= strap_pin_in;
                reset_seen <= 1'b0;
            end
        end
    end

    // The pin floats while either reset holds so the strap resistor sets its level.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_pin_oe_n <= 1'b1;
            strap_pin_out <= 1'b1;
        end else begin
            strap_pin_oe_n <= host_reset_drive;
            strap_pin_out <= serial1_request_to_send_n;
        end
    end

endmodule : cpka_strap_latch
